// file: i2c_slave_transmit_status_params.svh
// Purpose: Constants of the two-wire slave transmitter
// Assumes: Included by the design file only
// Notes:   Status codes, counts and reset values
`ifndef I2C_SLAVE_TRANSMIT_STATUS_PARAMS_SVH
`define I2C_SLAVE_TRANSMIT_STATUS_PARAMS_SVH

// ****************************************
// Status codes
// ****************************************
`define CODE_OWN_READ   8'ha8
`define CODE_ARB_READ   8'hb0
`define CODE_DATA_ACK   8'hb8
`define CODE_DATA_NACK  8'hc0
`define CODE_LAST_ACK   8'hc8
`define CODE_STOP_ADDR  8'ha0
`define CODE_NO_INFO    8'hf8
`define CODE_BUS_ERR    8'h00

// ****************************************
// Counts, bit positions and reset values
// ****************************************
`define BITS_PER_BYTE   4'h8
`define GC_ENABLE_BIT   0
`define RST_BYTE        8'h00
`define RST_OWN_ADDR    8'h00

`endif

// file: i2c_slave_transmit_status_pkg.sv
// Purpose: Types of the two-wire slave transmitter
// Assumes: Nothing
// Notes:   Bus-side state machine encoding
`default_nettype none

package i2c_slave_transmit_status_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_AACK = 3'h2,
        ST_WAIT = 3'h3,
        ST_TX   = 3'h4,
        ST_RACK = 3'h5
    } bus_state_e;

endpackage

`default_nettype wire

// file: i2c_slave_transmit_status.sv
// Purpose: Slave transmitter of the two-wire interface with status codes
// Assumes: Pins sampled by clk_sys; CPU side on clk_sys
// Notes:   Master and slave receiver live elsewhere
`timescale 1ns/100ps
`default_nettype none

`include "i2c_slave_transmit_status_params.svh"

module i2c_slave_transmit_status (
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    input  wire logic       scl_in,
    output logic            scl_out,
    output logic            scl_oe,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic       ctl_wr,
    input  wire logic       ctl_si,
    input  wire logic       ctl_ack_enable,
    input  wire logic       ctl_start_request,
    input  wire logic       ctl_stop_request,
    input  wire logic       data_wr,
    input  wire logic [7:0] data_wdata,
    input  wire logic       addr_wr,
    input  wire logic [7:0] addr_wdata,
    input  wire logic       arb_lost,
    output logic            si_flag,
    output logic            ack_enable,
    output logic            start_request,
    output logic            stop_request,
    output logic [7:0]      serial_status_reg,
    output logic [7:0]      serial_data_reg,
    output logic [7:0]      own_address_reg,
    output logic            start_gen,
    output logic            gc_hit
);
    import i2c_slave_transmit_status_pkg::*;

    // ****************************************
    // Pin synchronisers and edge detection
    // ****************************************
    logic       scl_s1_reg;
    logic       scl_s2_reg;
    logic       scl_d_reg;
    logic       sda_s1_reg;
    logic       sda_s2_reg;
    logic       sda_d_reg;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_ev;
    logic       stop_ev;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            scl_s1_reg <= 1'b1;
            scl_s2_reg <= 1'b1;
            scl_d_reg  <= 1'b1;
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
            sda_d_reg  <= 1'b1;
        end else begin
            scl_s1_reg <= scl_in;
            scl_s2_reg <= scl_s1_reg;
            scl_d_reg  <= scl_s2_reg;
            sda_s1_reg <= sda_in;
            sda_s2_reg <= sda_s1_reg;
            sda_d_reg  <= sda_s2_reg;
        end
    end

    assign scl_rise = scl_s2_reg & ~scl_d_reg;
    assign scl_fall = ~scl_s2_reg & scl_d_reg;
    assign start_ev = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
    assign stop_ev  = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;

    // ****************************************
    // Bus state machine
    // ****************************************
    bus_state_e state_reg;
    bus_state_e state_next;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic [7:0] code_reg;
    logic [7:0] code_next;
    logic       last_reg;
    logic       last_next;
    logic       si_set;
    logic       leave_req;
    logic       gc_next;
    logic       own_match;
    logic       gc_match;
    logic       recover;

    assign own_match = ack_enable
                     && (shift_reg[7:1] == own_address_reg[7:1]);
    assign gc_match  = ack_enable && own_address_reg[`GC_ENABLE_BIT]
                     && (shift_reg == `RST_BYTE);
    assign recover   = stop_request && !si_flag;

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        shift_next = shift_reg;
        code_next  = code_reg;
        last_next  = last_reg;
        si_set     = 1'b0;
        leave_req  = 1'b0;
        gc_next    = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (start_ev) begin
                    state_next = ST_ADDR;
                    cnt_next   = 4'h0;
                end
            end
            ST_ADDR: begin
                if (stop_ev) begin
                    state_next = ST_IDLE;
                end else if (start_ev) begin
                    cnt_next = 4'h0;
                end else if (scl_rise) begin
                    shift_next = {shift_reg[6:0], sda_s2_reg};
                    cnt_next   = cnt_reg + 4'h1;
                end else if (scl_fall && cnt_reg == `BITS_PER_BYTE) begin
                    if ((own_match && shift_reg[0]) || gc_match) begin
                        state_next = ST_AACK;
                    end else begin
                        state_next = ST_IDLE;
                    end
                end
            end
            ST_AACK: begin
                if (start_ev || stop_ev) begin
                    state_next = ST_IDLE;
                    si_set     = 1'b1;
                    code_next  = `CODE_BUS_ERR;
                end else if (scl_fall) begin
                    if (shift_reg[0]) begin
                        state_next = ST_WAIT;
                        si_set     = 1'b1;
                        code_next  = arb_lost ? `CODE_ARB_READ
                                              : `CODE_OWN_READ;
                    end else begin
                        gc_next    = 1'b1;
                        state_next = ST_IDLE;
                    end
                end
            end
            ST_WAIT: begin
                if (!si_flag) begin
                    if (code_reg == `CODE_OWN_READ
                        || code_reg == `CODE_ARB_READ
                        || code_reg == `CODE_DATA_ACK) begin
                        state_next = ST_TX;
                        shift_next = serial_data_reg;
                        cnt_next   = 4'h0;
                        last_next  = !ack_enable;
                    end else begin
                        state_next = ST_IDLE;
                        leave_req  = 1'b1;
                    end
                end
            end
            ST_TX: begin
                if (start_ev || stop_ev) begin
                    si_set = 1'b1;
                    if (cnt_reg <= 4'h1) begin
                        state_next = ST_WAIT;
                        code_next  = `CODE_STOP_ADDR;
                    end else begin
                        state_next = ST_IDLE;
                        code_next  = `CODE_BUS_ERR;
                    end
                end else if (scl_rise) begin
                    cnt_next = cnt_reg + 4'h1;
                end else if (scl_fall) begin
                    if (cnt_reg == `BITS_PER_BYTE) begin
                        state_next = ST_RACK;
                    end else begin
                        shift_next = {shift_reg[6:0], 1'b1};
                    end
                end
            end
            ST_RACK: begin
                if (start_ev || stop_ev) begin
                    state_next = ST_IDLE;
                    si_set     = 1'b1;
                    code_next  = `CODE_BUS_ERR;
                end else if (scl_rise) begin
                    shift_next[0] = sda_s2_reg;
                end else if (scl_fall) begin
                    state_next = ST_WAIT;
                    si_set     = 1'b1;
                    if (shift_reg[0]) begin
                        code_next = `CODE_DATA_NACK;
                    end else if (last_reg) begin
                        code_next = `CODE_LAST_ACK;
                    end else begin
                        code_next = `CODE_DATA_ACK;
                    end
                end
            end
            default: begin
                state_next = ST_IDLE;
                si_set     = 1'b1;
                code_next  = `CODE_BUS_ERR;
            end
        endcase
        if (recover) begin
            state_next = ST_IDLE;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= 4'h0;
            shift_reg <= `RST_BYTE;
            code_reg  <= `CODE_NO_INFO;
            last_reg  <= 1'b0;
            gc_hit    <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            shift_reg <= shift_next;
            code_reg  <= code_next;
            last_reg  <= last_next;
            gc_hit    <= gc_next;
        end
    end

    // ****************************************
    // Control bits, data and own address registers
    // ****************************************
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            si_flag <= 1'b0;
        end else if (si_set) begin
            si_flag <= 1'b1;
        end else if (ctl_wr) begin
            si_flag <= ctl_si;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ack_enable    <= 1'b0;
            start_request <= 1'b0;
        end else if (ctl_wr) begin
            ack_enable    <= ctl_ack_enable;
            start_request <= ctl_start_request;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            stop_request <= 1'b0;
        end else if (ctl_wr) begin
            stop_request <= ctl_stop_request;
        end else if (recover) begin
            stop_request <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            serial_data_reg <= `RST_BYTE;
        end else if (data_wr) begin
            serial_data_reg <= data_wdata;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            own_address_reg <= `RST_OWN_ADDR;
        end else if (addr_wr) begin
            own_address_reg <= addr_wdata;
        end
    end

    // ****************************************
    // Status register view
    // ****************************************
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            serial_status_reg <= `CODE_NO_INFO;
        end else begin
            serial_status_reg <= si_next_view() ? code_next
                                                : `CODE_NO_INFO;
        end
    end

    function automatic logic si_next_view();
        return si_set || (ctl_wr ? ctl_si : si_flag);
    endfunction

    // ****************************************
    // Bus busy and pending START
    // ****************************************
    logic busy_reg;
    logic pend_reg;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            busy_reg <= 1'b0;
        end else if (start_ev) begin
            busy_reg <= 1'b1;
        end else if (stop_ev || recover) begin
            busy_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pend_reg  <= 1'b0;
            start_gen <= 1'b0;
        end else begin
            start_gen <= 1'b0;
            if (leave_req && start_request) begin
                pend_reg <= 1'b1;
            end else if (pend_reg && !busy_reg) begin
                pend_reg  <= 1'b0;
                start_gen <= 1'b1;
            end
        end
    end

    // ****************************************
    // Open-drain pin drive
    // ****************************************
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe  = (state_reg == ST_WAIT)
                   && (code_reg != `CODE_STOP_ADDR);
    // released unless acking or sending 0
    assign sda_oe  = (state_reg == ST_AACK)
                   || ((state_reg == ST_TX) && !shift_reg[7]);

endmodule

`default_nettype wire

// file: i2c_slave_transmit_status_monitor.sv
// Purpose: Port checks of the two-wire slave transmitter
// Assumes: Bound to the design top, one clk_sys domain
// Notes:   Watches only design outputs against their causes
`timescale 1ns/100ps
`default_nettype none
module i2c_slave_transmit_status_monitor (
    input wire logic       clk_sys,
    input wire logic       sys_rst,
    input wire logic       scl_oe,
    input wire logic       sda_oe,
    input wire logic       arb_lost,
    input wire logic       si_flag,
    input wire logic       ack_enable,
    input wire logic       stop_request,
    input wire logic [7:0] serial_status_reg,
    input wire logic [7:0] own_address_reg,
    input wire logic       gc_hit
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    // ****************
    // Checks
    // ****************
    status_idle_a: assert property (
        !si_flag |-> serial_status_reg == 8'hf8) else $error("idle code wrong");
    clock_stretch_a: assert property (
        si_flag && serial_status_reg inside {8'ha8, 8'hb0, 8'hb8} |-> scl_oe)
        else $error("clock not held");
    err_release_a: assert property (
        si_flag && serial_status_reg == 8'h00 |-> !scl_oe && !sda_oe)
        else $error("lines held after bus error");
    ack_driven_a: assert property (
        $rose(si_flag) && serial_status_reg inside {8'ha8, 8'hb0} |-> $past(sda_oe, 2))
        else $error("address not acked");
    ack_enabled_a: assert property (
        $rose(si_flag) && serial_status_reg inside {8'ha8, 8'hb0} |-> $past(ack_enable, 2))
        else $error("addressed while disabled");
    arb_code_a: assert property (
        $rose(si_flag) && serial_status_reg inside {8'ha8, 8'hb0}
        |-> (serial_status_reg == 8'hb0) == $past(arb_lost)) else $error("arbitration code wrong");
    gc_enable_a: assert property (
        gc_hit |-> own_address_reg[0] && ack_enable) else $error("general call not enabled");
    stop_clear_a: assert property (
        stop_request && !si_flag |=> !stop_request) else $error("stop request kept");
    code_stable_a: assert property (
        si_flag && $past(si_flag) |-> $stable(serial_status_reg)) else $error("code moved");
    last_release_a: assert property (
        $fell(si_flag) && $past(serial_status_reg) inside {8'hc0, 8'hc8}
        |=> (!sda_oe && !scl_oe) [*8]) else $error("lines held after last byte");
endmodule
bind i2c_slave_transmit_status i2c_slave_transmit_status_monitor u_monitor (
    .clk_sys, .sys_rst, .scl_oe, .sda_oe, .arb_lost, .si_flag, .ack_enable,
    .stop_request, .serial_status_reg, .own_address_reg, .gc_hit
);
`default_nettype wire

// file: i2c_master_rx_model.sv
// Purpose: Master receiver on the two-wire bus
// Assumes: Open drain lines with pull-ups
// Notes:   Bit time 320 ns, waits while the clock is stretched
`timescale 1ns/100ps
`default_nettype none
module i2c_master_rx_model (
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_low,
    output logic      sda_low
);
    // ****************
    // Bus primitives
    // ****************
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    task automatic rise();
        int n;
        n = 0;
        scl_low = 1'b0;
        do begin
            #40;
            n++;
        end while (scl !== 1'b1 && n < 5000);
    endtask
    task automatic put(input logic b);
        sda_low = !b;
        #80 rise();
        #120 scl_low = 1'b1;
        #80;
    endtask
    task automatic get(output logic b);
        sda_low = 1'b0;
        #80 rise();
        #40 b = sda;
        #80 scl_low = 1'b1;
        #80;
    endtask
    task automatic start();
        #160 sda_low = 1'b1;
        #160 scl_low = 1'b1;
        #80;
    endtask
    task automatic stop();
        sda_low = 1'b1;
        #80 rise();
        #120 sda_low = 1'b0;
        #160;
    endtask
    task automatic send(input logic [7:0] v, output logic ack);
        for (int i = 7; i >= 0; i--)
            put(v[i]);
        get(ack);
    endtask
    task automatic recv(input logic mack, output logic [7:0] v);
        for (int i = 7; i >= 0; i--)
            get(v[i]);
        put(mack);
    endtask
endmodule
`default_nettype wire

// file: i2c_slave_transmit_status_test.sv
// Purpose: Self-checking bench of the two-wire slave transmitter
// Assumes: Master receiver model drives the pins
// Notes:   Pins are open drain with pull-ups
`timescale 1ns/100ps
`default_nettype none
module i2c_slave_transmit_status_test;
    logic       clk_sys, sys_rst, ctl_wr, ctl_si, ctl_ack_enable, ctl_start_request;
    logic       ctl_stop_request, data_wr, addr_wr, arb_lost, scl_out, scl_oe, sda_out;
    logic       sda_oe, si_flag, ack_enable, start_request, stop_request, start_gen;
    logic       gc_hit, m_scl, m_sda;
    logic [7:0] data_wdata, addr_wdata, serial_status_reg, serial_data_reg, own_address_reg;
    int         fail_count, num_checks, sg_cnt, gc_cnt;
    wire logic  scl_in = (scl_oe ? scl_out : 1'b1) & !m_scl;
    wire logic  sda_in = (sda_oe ? sda_out : 1'b1) & !m_sda;
    i2c_slave_transmit_status u_i2c_slave_transmit_status (
        .clk_sys, .sys_rst, .scl_in, .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe,
        .ctl_wr, .ctl_si, .ctl_ack_enable, .ctl_start_request, .ctl_stop_request,
        .data_wr, .data_wdata, .addr_wr, .addr_wdata, .arb_lost, .si_flag, .ack_enable,
        .start_request, .stop_request, .serial_status_reg, .serial_data_reg,
        .own_address_reg, .start_gen, .gc_hit);
    i2c_master_rx_model u_master (.scl(scl_in), .sda(sda_in), .scl_low(m_scl), .sda_low(m_sda));
    // ****************
    // Helpers
    // ****************
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (start_gen === 1'b1) sg_cnt <= sg_cnt + 1;
        if (gc_hit === 1'b1) gc_cnt <= gc_cnt + 1;
    end
    task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Kind 0 control {si, ack, start, stop}, 1 data, 2 own address
    task automatic wr(input logic [1:0] k, input logic [7:0] v);
        @(posedge clk_sys);
        {addr_wr, data_wr, ctl_wr} <= {k == 2'h2, k == 2'h1, k == 2'h0};
        {ctl_si, ctl_ack_enable, ctl_start_request, ctl_stop_request} <= v[3:0];
        data_wdata <= v;
        addr_wdata <= v;
        @(posedge clk_sys);
        {addr_wr, data_wr, ctl_wr} <= 3'h0;
        @(negedge clk_sys);
    endtask
    task automatic wait_si();
        int n;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (si_flag !== 1'b1 && n < 200);
        chk("flag", {7'h0, si_flag}, 8'h01);
    endtask
    task automatic own_read(input logic [7:0] code);
        logic a;
        u_master.start();
        u_master.send(8'ha5, a);
        chk("address ack", {7'h0, a}, 8'h00);
        wait_si();
        chk("status", serial_status_reg, code);
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_reset();
        chk("status", serial_status_reg, 8'hf8);
        chk("control", {2'h0, si_flag, ack_enable, start_request, stop_request, scl_oe, sda_oe},
            8'h00);
        chk("own address", own_address_reg, 8'h00);
        chk("data", serial_data_reg, 8'h00);
        wr(2'h2, 8'ha4);
        wr(2'h0, 8'h04);
        $display("reset test done");
    endtask
    task automatic t_err();
        logic b;
        own_read(8'ha8);
        wr(2'h1, 8'hff);
        wr(2'h0, 8'h04);
        u_master.get(b);
        u_master.stop();
        wait_si();
        chk("error status", serial_status_reg, 8'h00);
        chk("lines", {6'h0, scl_oe, sda_oe}, 8'h00);
        wr(2'h0, 8'h05);
        repeat (2) @(negedge clk_sys);
        chk("recovery", {5'h0, si_flag, ack_enable, stop_request}, 8'h02);
        $display("bus error test done");
    endtask
    task automatic t_addr();
        logic [18:0] tv [5];
        logic a;
        int g;
        tv = '{{8'ha4, 8'ha4, 3'b110}, {8'ha4, 8'ha5, 3'b010}, {8'ha4, 8'h00, 3'b110},
               {8'ha5, 8'h00, 3'b101}, {8'ha5, 8'ha7, 3'b110}};
        for (int i = 0; i < 5; i++) begin
            wr(2'h2, tv[i][18:11]);
            wr(2'h0, {5'h0, tv[i][2], 2'h0});
            g = gc_cnt;
            u_master.start();
            u_master.send(tv[i][10:3], a);
            u_master.stop();
            chk("ack", {7'h0, a}, {7'h0, tv[i][1]});
            chk("general call", 8'(gc_cnt - g), {7'h0, tv[i][0]});
        end
        wr(2'h2, 8'ha4);
        wr(2'h0, 8'h04);
        $display("address test done");
    endtask
    task automatic t_read();
        logic [7:0] d;
        own_read(8'ha8);
        chk("stretch", {7'h0, scl_oe}, 8'h01);
        wr(2'h1, 8'h3c);
        chk("data reg", serial_data_reg, 8'h3c);
        wr(2'h0, 8'h04);
        u_master.recv(1'b0, d);
        chk("data", d, 8'h3c);
        wait_si();
        chk("status", serial_status_reg, 8'hb8);
        wr(2'h1, 8'h96);
        wr(2'h0, 8'h00);
        u_master.recv(1'b0, d);
        chk("last data", d, 8'h96);
        wait_si();
        chk("status", serial_status_reg, 8'hc8);
        wr(2'h0, 8'h06);
        u_master.recv(1'b0, d);
        chk("released data", d, 8'hff);
        chk("status", serial_status_reg, 8'hf8);
        chk("early start", 8'(sg_cnt), 8'h00);
        u_master.stop();
        repeat (20) @(negedge clk_sys);
        chk("start", {7'h0, sg_cnt != 0}, 8'h01);
        wr(2'h0, 8'h04);
        $display("read test done");
    endtask
    task automatic t_nack();
        logic [7:0] d;
        @(posedge clk_sys) arb_lost <= 1'b1;
        @(negedge clk_sys);
        own_read(8'hb0);
        @(posedge clk_sys) arb_lost <= 1'b0;
        wr(2'h1, 8'h5a);
        wr(2'h0, 8'h04);
        u_master.recv(1'b1, d);
        wait_si();
        chk("status", serial_status_reg, 8'hc0);
        wr(2'h0, 8'h04);
        u_master.stop();
        own_read(8'ha8);
        wr(2'h1, 8'hff);
        wr(2'h0, 8'h04);
        u_master.stop();
        wait_si();
        chk("status", serial_status_reg, 8'ha0);
        wr(2'h0, 8'h04);
        repeat (2) @(negedge clk_sys);
        chk("flag", {7'h0, si_flag}, 8'h00);
        $display("nack test done");
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        {sys_rst, ctl_wr, data_wr, addr_wr, arb_lost} = 5'h10;
        {ctl_si, ctl_ack_enable, ctl_start_request, ctl_stop_request} = 4'h0;
        data_wdata = 8'h00;
        addr_wdata = 8'h00;
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (3) @(negedge clk_sys);
        t_reset();
        t_err();
        t_addr();
        t_read();
        t_nack();
        end_sim();
    end
    initial begin
        #500000;
        fail_count++;
        end_sim();
    end
endmodule
`default_nettype wire
